// [common/gpio_decode_pkg.sv]
`default_nettype none
package gpio_decode_pkg;
   localparam int PIN_COUNT = 16;
   localparam int REG_COUNT = 12;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Register byte offsets
   localparam logic [7:0] ADDR_BANK_B_DECODE_MODE = 8'h20;
   localparam logic [7:0] ADDR_BANK_A_DECODE_MODE = 8'h21;
   localparam logic [7:0] ADDR_BANK_B_TWO_INPUT_TABLE = 8'h22;
   localparam logic [7:0] ADDR_BANK_A_TWO_INPUT_TABLE = 8'h23;
   localparam logic [7:0] ADDR_BANK_B_UPPER_THREE_INPUT_TABLE = 8'h24;
   localparam logic [7:0] ADDR_BANK_A_UPPER_THREE_INPUT_TABLE = 8'h25;
   localparam logic [7:0] ADDR_BANK_B_LOWER_THREE_INPUT_TABLE = 8'h26;
   localparam logic [7:0] ADDR_BANK_A_LOWER_THREE_INPUT_TABLE = 8'h27;
   localparam logic [7:0] ADDR_BANK_A_DUAL_TABLE_FIRST = 8'h28;
   localparam logic [7:0] ADDR_BANK_A_DUAL_TABLE_SECOND = 8'h29;
   localparam logic [7:0] ADDR_BANK_B_DUAL_TABLE_FIRST = 8'h2a;
   localparam logic [7:0] ADDR_BANK_B_DUAL_TABLE_SECOND = 8'h2b;
   // Storage slots: slot = offset - first offset
   localparam logic [7:0] ADDR_FIRST = ADDR_BANK_B_DECODE_MODE;
   localparam logic [7:0] ADDR_LAST = ADDR_BANK_B_DUAL_TABLE_SECOND;
   localparam logic [3:0] IDX_MODE_B = 4'h0;
   localparam logic [3:0] IDX_MODE_A = 4'h1;
   localparam logic [3:0] IDX_TAB0_B = 4'h2;
   localparam logic [3:0] IDX_TAB0_A = 4'h3;
   localparam logic [3:0] IDX_TAB1_B = 4'h4;
   localparam logic [3:0] IDX_TAB1_A = 4'h5;
   localparam logic [3:0] IDX_TAB2_B = 4'h6;
   localparam logic [3:0] IDX_TAB2_A = 4'h7;
   localparam logic [3:0] IDX_TAB3_A = 4'h8;
   localparam logic [3:0] IDX_TAB4_A = 4'h9;
   localparam logic [3:0] IDX_TAB3_B = 4'ha;
   localparam logic [3:0] IDX_TAB4_B = 4'hb;
   // Mode field positions and codes
   localparam int UPPER_FIELD_LSB = 4;
   localparam int LOWER_FIELD_LSB = 0;
   localparam logic [1:0] MODE_GPIO = 2'h0;
   localparam logic [1:0] MODE_TWO_TO_ONE = 2'h1;
   localparam logic [1:0] MODE_THREE_TO_ONE = 2'h2;
   localparam logic [1:0] MODE_THREE_TO_TWO = 2'h3;
endpackage : gpio_decode_pkg
`default_nettype wire

// [logic/gpio_lookup_decode.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Upper-B field 00 leaves pins 15..12 as plain GPIO, except pin 12 when Lower-B is 11; 11 reserved.
// (RULE2) Upper-B 01 drives pin 14 from upper half of B table 0.
// (RULE3) Upper-B 10 drives pin 15 from B table 1 indexed by pins 14..12.
// (RULE4) Lower-B field 00 leaves pins 11..8 as plain GPIO.
// (RULE5) Lower-B 01 drives pin 10 from lower half of B table 0.
// (RULE6) Lower-B 10 drives pin 11 from a table indexed by pins 10..8.
// (RULE7) Lower-B 11 drives pins 12 and 11 from B dual tables.
// (RULE8) Upper-A field 00 leaves pins 7..4 as plain GPIO, except pin 4 when Lower-A is 11; 11 reserved.
// (RULE9) Upper-A 01 drives pin 6 from upper half of A table 0.
// (RULE10) Upper-A 10 drives pin 7 from A table 1 indexed by pins 6..4.
// (RULE11) Lower-A field 00 leaves pins 3..0 as plain GPIO.
// (RULE12) Lower-A 01 drives pin 2 from lower half of A table 0.
// (RULE13) Lower-A 10 drives pin 3 from A table 2 indexed by pins 2..0.
// (RULE14) Lower-A 11 drives pins 4 and 3 from A dual tables.
// (RULE15) Host keeps reserved mode bits 7:6 and 3:2 at zero.
// (RULE16) B table 0 bits 7..4 give pin 14 for inputs 11..00.
// (RULE17) B table 0 bits 3..0 give pin 10 for inputs 11..00.
// (RULE18) A table 0 bits 7..4 give pin 6 for inputs 11..00.
// (RULE19) A table 0 bits 3..0 give pin 2 for inputs 11..00.
// (RULE20) Three-input tables: bit n is output for input value n.
// (RULE21) Tables act only in their mode; decode follows inputs combinationally.
module gpio_lookup_decode
   import gpio_decode_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [PIN_COUNT-1:0] gpioIn,
   input wire logic [PIN_COUNT-1:0] coreOut,
   input wire logic [PIN_COUNT-1:0] coreOe,
   output logic [PIN_COUNT-1:0] pinOut,
   output logic [PIN_COUNT-1:0] pinOe
);

   function automatic logic regHit(input logic [7:0] addr);
      regHit = (addr >= ADDR_FIRST) && (addr <= ADDR_LAST);
   endfunction : regHit

   function automatic logic [3:0] regIdx(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - ADDR_FIRST;
      regIdx = diff[3:0];
   endfunction : regIdx

   // Three-input lookup: bit n answers input value n
   function automatic logic lut3(input logic [7:0] tab, input logic [2:0] sel);
      lut3 = tab[sel];
   endfunction : lut3

   logic [7:0] regs_r [REG_COUNT];
   logic [7:0] regs_nxt [REG_COUNT];
   logic [7:0] regRdData_r;
   logic [7:0] regRdData_nxt;

   always_comb
   begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
         regs_nxt[i] = regs_r[i];
      end
      regRdData_nxt = regRdData_r;
      // Reserved mode bits are stored as written; host keeps them zero
      if (regWr && regHit(regAddr))
      begin
         regs_nxt[regIdx(regAddr)] = regWrData;
      end
      // Unmapped reads answer zero rather than holding stale data
      if (regRd)
      begin
         regRdData_nxt = regHit(regAddr) ? regs_r[regIdx(regAddr)] : 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            regs_r[i] <= REG_RESET;
         end
         regRdData_r <= 8'h00;
      end
      else if (ce)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            regs_r[i] <= regs_nxt[i];
         end
         regRdData_r <= regRdData_nxt;
      end
   end

   assign regRdData = regRdData_r;

   logic [1:0] upperB;
   logic [1:0] lowerB;
   logic [1:0] upperA;
   logic [1:0] lowerA;

   assign upperB = regs_r[IDX_MODE_B][UPPER_FIELD_LSB +: 2];
   assign lowerB = regs_r[IDX_MODE_B][LOWER_FIELD_LSB +: 2];
   assign upperA = regs_r[IDX_MODE_A][UPPER_FIELD_LSB +: 2];
   assign lowerA = regs_r[IDX_MODE_A][LOWER_FIELD_LSB +: 2];

   // Decode is purely combinational so table outputs track pins with no lag;
   // a decoded pin is always driven, whatever the core direction says.
   always_comb
   begin
      pinOut = coreOut; // RULE1 RULE4 RULE8 RULE11 RULE21
      pinOe = coreOe;
      case (upperB)
         MODE_TWO_TO_ONE:
         begin
            pinOut[14] = regs_r[IDX_TAB0_B][{1'b1, gpioIn[13:12]}]; // RULE2 RULE16
            pinOe[14] = 1'b1;
         end
         MODE_THREE_TO_ONE:
         begin
            pinOut[15] = lut3(regs_r[IDX_TAB1_B], gpioIn[14:12]); // RULE3 RULE20
            pinOe[15] = 1'b1;
         end
         default:
         begin
            pinOe[15] = pinOe[15]; // RULE1
         end
      endcase
      case (lowerB)
         MODE_TWO_TO_ONE:
         begin
            pinOut[10] = regs_r[IDX_TAB0_B][{1'b0, gpioIn[9:8]}]; // RULE5 RULE17
            pinOe[10] = 1'b1;
         end
         MODE_THREE_TO_ONE:
         begin
            pinOut[11] = lut3(regs_r[IDX_TAB2_B], gpioIn[10:8]); // RULE6 RULE20
            pinOe[11] = 1'b1;
         end
         MODE_THREE_TO_TWO:
         begin
            pinOut[11] = lut3(regs_r[IDX_TAB3_B], gpioIn[10:8]); // RULE7
            pinOut[12] = lut3(regs_r[IDX_TAB4_B], gpioIn[10:8]); // RULE7
            pinOe[12:11] = 2'h3;
         end
         default:
         begin
            pinOe[11] = pinOe[11]; // RULE4
         end
      endcase
      case (upperA)
         MODE_TWO_TO_ONE:
         begin
            pinOut[6] = regs_r[IDX_TAB0_A][{1'b1, gpioIn[5:4]}]; // RULE9 RULE18
            pinOe[6] = 1'b1;
         end
         MODE_THREE_TO_ONE:
         begin
            pinOut[7] = lut3(regs_r[IDX_TAB1_A], gpioIn[6:4]); // RULE10 RULE20
            pinOe[7] = 1'b1;
         end
         default:
         begin
            pinOe[7] = pinOe[7]; // RULE8
         end
      endcase
      case (lowerA)
         MODE_TWO_TO_ONE:
         begin
            pinOut[2] = regs_r[IDX_TAB0_A][{1'b0, gpioIn[1:0]}]; // RULE12 RULE19
            pinOe[2] = 1'b1;
         end
         MODE_THREE_TO_ONE:
         begin
            pinOut[3] = lut3(regs_r[IDX_TAB2_A], gpioIn[2:0]); // RULE13 RULE20
            pinOe[3] = 1'b1;
         end
         MODE_THREE_TO_TWO:
         begin
            pinOut[3] = lut3(regs_r[IDX_TAB3_A], gpioIn[2:0]); // RULE14
            pinOut[4] = lut3(regs_r[IDX_TAB4_A], gpioIn[2:0]); // RULE14
            pinOe[4:3] = 2'h3;
         end
         default:
         begin
            pinOe[3] = pinOe[3]; // RULE11
         end
      endcase
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_all_gpio;
      regs_r[IDX_MODE_A] == 8'h00 && regs_r[IDX_MODE_B] == 8'h00;
   endsequence

   sequence s_table_write;
      ce && regWr && regAddr >= ADDR_BANK_B_TWO_INPUT_TABLE && regAddr <= ADDR_LAST;
   endsequence

   sequence s_reg_write;
      ce && regWr && regHit(regAddr);
   endsequence

   a_gpio_upper_b: assert property (upperB == MODE_GPIO // RULE1
      |-> pinOut[15:13] == coreOut[15:13] && pinOe[15:13] == coreOe[15:13])
      else $error("upper B nibble not plain GPIO");
   a_upper_b_pair: assert property (upperB == MODE_TWO_TO_ONE // RULE2
      |-> pinOe[14] && pinOut[14] == regs_r[IDX_TAB0_B][4 + gpioIn[13:12]])
      else $error("pin 14 decode wrong");
   a_upper_b_triple: assert property (upperB == MODE_THREE_TO_ONE // RULE3
      |-> pinOe[15] && pinOut[15] == regs_r[IDX_TAB1_B][gpioIn[14:12]])
      else $error("pin 15 decode wrong");
   a_gpio_lower_b: assert property (lowerB == MODE_GPIO // RULE4
      |-> pinOut[11:8] == coreOut[11:8] && pinOe[11:8] == coreOe[11:8])
      else $error("lower B nibble not plain GPIO");
   a_lower_b_pair: assert property (lowerB == MODE_TWO_TO_ONE // RULE5
      |-> pinOe[10] && pinOut[10] == regs_r[IDX_TAB0_B][gpioIn[9:8]])
      else $error("pin 10 decode wrong");
   a_lower_b_triple: assert property (lowerB == MODE_THREE_TO_ONE // RULE6
      |-> pinOe[11] && pinOut[11] == regs_r[IDX_TAB2_B][gpioIn[10:8]])
      else $error("pin 11 decode wrong");
   a_lower_b_dual: assert property (lowerB == MODE_THREE_TO_TWO // RULE7
      |-> pinOe[12:11] == 2'h3
         && pinOut[11] == regs_r[IDX_TAB3_B][gpioIn[10:8]]
         && pinOut[12] == regs_r[IDX_TAB4_B][gpioIn[10:8]])
      else $error("pins 12 and 11 decode wrong");
   a_gpio_upper_a: assert property (upperA == MODE_GPIO && lowerA != MODE_THREE_TO_TWO // RULE8
      |-> pinOut[7:4] == coreOut[7:4] && pinOe[7:4] == coreOe[7:4])
      else $error("upper A nibble not plain GPIO");
   a_upper_a_pair: assert property (upperA == MODE_TWO_TO_ONE // RULE9
      |-> pinOe[6] && pinOut[6] == regs_r[IDX_TAB0_A][4 + gpioIn[5:4]])
      else $error("pin 6 decode wrong");
   a_upper_a_triple: assert property (upperA == MODE_THREE_TO_ONE // RULE10
      |-> pinOe[7] && pinOut[7] == regs_r[IDX_TAB1_A][gpioIn[6:4]])
      else $error("pin 7 decode wrong");
   a_gpio_lower_a: assert property (lowerA == MODE_GPIO // RULE11
      |-> pinOut[3:0] == coreOut[3:0] && pinOe[3:0] == coreOe[3:0])
      else $error("lower A nibble not plain GPIO");
   a_lower_a_pair: assert property (lowerA == MODE_TWO_TO_ONE // RULE12
      |-> pinOe[2] && pinOut[2] == regs_r[IDX_TAB0_A][gpioIn[1:0]])
      else $error("pin 2 decode wrong");
   a_lower_a_triple: assert property (lowerA == MODE_THREE_TO_ONE // RULE13
      |-> pinOe[3] && pinOut[3] == regs_r[IDX_TAB2_A][gpioIn[2:0]])
      else $error("pin 3 decode wrong");
   a_lower_a_dual: assert property (lowerA == MODE_THREE_TO_TWO // RULE14
      |-> pinOe[4:3] == 2'h3
         && pinOut[3] == regs_r[IDX_TAB3_A][gpioIn[2:0]]
         && pinOut[4] == regs_r[IDX_TAB4_A][gpioIn[2:0]])
      else $error("pins 4 and 3 decode wrong");
   a_table_isolated: assert property (s_all_gpio ##0 s_table_write // RULE21
      |=> pinOut == coreOut && pinOe == coreOe)
      else $error("table write leaked onto pins");
   a_write_readback: assert property (s_reg_write ##1 (ce && regRd && !regWr
      && regAddr == $past(regAddr))
      |=> regRdData == $past(regWrData, 2))
      else $error("register readback mismatch");

endmodule : gpio_lookup_decode

`default_nettype wire

// [tb/pin_world.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_world
   import gpio_decode_pkg::*;
(
   input wire logic [PIN_COUNT-1:0] pinOut,
   input wire logic [PIN_COUNT-1:0] pinOe,
   input wire logic [PIN_COUNT-1:0] extLevel,
   output logic [PIN_COUNT-1:0] gpioIn
);
   // Device wins where it drives, so the outside load never fights it
   assign gpioIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pin_world
`default_nettype wire

// [tb/gpio_lookup_decode_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_lookup_decode_tb;
   import gpio_decode_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic [15:0] gpioIn, pinOut, pinOe, mv, me, ml;
   logic [15:0] coreOut = 16'h0000;
   logic [15:0] coreOe = 16'h0000;
   logic [15:0] extLevel = 16'h0000;
   logic pinChk = 1'b0;
   logic rdTaken, pinTaken;
   logic [7:0] shadow [REG_COUNT];
   logic [7:0] rq[$];
   logic [31:0] pq[$];
   int n_fail = 0;
   int compares = 0;
   integer seed = 32'he2836913;
   always #50 clk = ~clk;
   gpio_lookup_decode u_gpio_lookup_decode (.clk(clk), .rst_b(rst_b), .ce(ce),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .gpioIn(gpioIn), .coreOut(coreOut), .coreOe(coreOe),
      .pinOut(pinOut), .pinOe(pinOe));
   pin_world u_pin_world (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
      .gpioIn(gpioIn));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic summarize;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   function automatic logic mapped(input logic [7:0] a);
      return a >= ADDR_FIRST && a <= ADDR_LAST;
   endfunction : mapped
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      ce = en;
      if (en && mapped(a))
         shadow[a - ADDR_FIRST] = d;
      @(negedge clk);
      regWr = 1'b0;
      ce = 1'b1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      regAddr = a;
      regRd = 1'b1;
      rq.push_back(mapped(a) ? shadow[a - ADDR_FIRST] : 8'h00);
      @(negedge clk);
      regRd = 1'b0;
   endtask : rd
   // Write and read together (old value back), then read alone on the next edge
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      regRd = 1'b1;
      rq.push_back(mapped(a) ? shadow[a - ADDR_FIRST] : 8'h00);
      if (mapped(a))
         shadow[a - ADDR_FIRST] = d;
      @(negedge clk);
      regWr = 1'b0;
      rq.push_back(mapped(a) ? shadow[a - ADDR_FIRST] : 8'h00);
      @(negedge clk);
      regRd = 1'b0;
   endtask : wrrd
   function automatic void put(input int p, input logic b);
      mv[p] = b;
      me[p] = 1'b1;
      ml[p] = b;
   endfunction : put
   // Lower fields first: their outputs on pins 4 and 12 feed the upper decodes
   function automatic logic [31:0] model();
      mv = coreOut;
      me = coreOe;
      ml = (coreOe & coreOut) | (~coreOe & extLevel);
      case (shadow[IDX_MODE_A][1:0])
         MODE_TWO_TO_ONE: put(2, shadow[IDX_TAB0_A][{1'b0, ml[1:0]}]);
         MODE_THREE_TO_ONE: put(3, shadow[IDX_TAB2_A][ml[2:0]]);
         MODE_THREE_TO_TWO:
         begin
            put(3, shadow[IDX_TAB3_A][ml[2:0]]);
            put(4, shadow[IDX_TAB4_A][ml[2:0]]);
         end
         default: ;
      endcase
      case (shadow[IDX_MODE_A][5:4])
         MODE_TWO_TO_ONE: put(6, shadow[IDX_TAB0_A][{1'b1, ml[5:4]}]);
         MODE_THREE_TO_ONE: put(7, shadow[IDX_TAB1_A][ml[6:4]]);
         default: ;
      endcase
      case (shadow[IDX_MODE_B][1:0])
         MODE_TWO_TO_ONE: put(10, shadow[IDX_TAB0_B][{1'b0, ml[9:8]}]);
         MODE_THREE_TO_ONE: put(11, shadow[IDX_TAB2_B][ml[10:8]]);
         MODE_THREE_TO_TWO:
         begin
            put(11, shadow[IDX_TAB3_B][ml[10:8]]);
            put(12, shadow[IDX_TAB4_B][ml[10:8]]);
         end
         default: ;
      endcase
      case (shadow[IDX_MODE_B][5:4])
         MODE_TWO_TO_ONE: put(14, shadow[IDX_TAB0_B][{1'b1, ml[13:12]}]);
         MODE_THREE_TO_ONE: put(15, shadow[IDX_TAB1_B][ml[14:12]]);
         default: ;
      endcase
      return {me, mv};
   endfunction : model
   task automatic pins;
      @(negedge clk);
      coreOut = 16'($random(seed));
      coreOe = 16'($random(seed));
      extLevel = 16'($random(seed));
      pinChk = 1'b1;
      pq.push_back(model());
      @(negedge clk);
      pinChk = 1'b0;
   endtask : pins
   always @(posedge clk)
   begin
      rdTaken = regRd & ce & rst_b;
      pinTaken = pinChk;
      #20;
      if (rdTaken)
         check({24'h000000, regRdData}, {24'h000000, rq.pop_front()});
      if (pinTaken)
         check({pinOe, pinOut}, pq.pop_front());
   end
   initial
   begin
      for (int i = 0; i < REG_COUNT; i++)
         shadow[i] = REG_RESET;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      // Last address is one past the map and must read as zero
      for (int a = 32; a <= 44; a++)
         rd(8'(a));
      for (int i = 2; i < REG_COUNT; i++)
         wr(ADDR_FIRST + 8'(i), 8'($random(seed)), 1'b1);
      wr(8'h30, 8'h5a, 1'b1);
      rd(8'h30);
      for (int m = 0; m < 16; m++)
      begin
         wr(ADDR_BANK_A_DECODE_MODE, {2'h0, 2'(m >> 2), 2'h0, 2'(m)}, 1'b1);
         wr(ADDR_BANK_B_DECODE_MODE, {2'h0, 2'(m), 2'h0, 2'(m >> 2)}, 1'b1);
         wr(ADDR_BANK_B_TWO_INPUT_TABLE, 8'($random(seed)), 1'b1);
         wrrd(ADDR_BANK_A_TWO_INPUT_TABLE, 8'($random(seed)));
         // Clock enable low must drop this write
         wr(ADDR_BANK_A_DECODE_MODE, 8'h33, 1'b0);
         repeat (12) pins();
         rd(ADDR_BANK_A_DECODE_MODE);
      end
      for (int i = 2; i < REG_COUNT; i++)
         rd(ADDR_FIRST + 8'(i));
      summarize();
   end
   // Run needs about 670 cycles; five thousand leaves ample margin
   initial
   begin
      #500000;
      n_fail++;
      summarize();
   end
endmodule : gpio_lookup_decode_tb
`default_nettype wire
